// ===== prescaled_dual_timer_pwm.sv
// Prescaled dual 8-bit / 16-bit timer with toggle and PWM outputs, AXI4-Lite slave
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
module prescaled_dual_timer_pwm #(
	parameter int ADDR_W = prescaled_dual_timer_pwm_pkg::ADDR_W
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Count sources
	input  wire logic              event_pin_a,
	input  wire logic              event_pin_b,
	input  wire logic              oscillator_a,
	input  wire logic              oscillator_b,
	// Timer outputs
	output logic                   low_wave_out,
	output logic                   high_wave_out,
	output logic                   irq_request
);

	// Register state
	prescaled_dual_timer_pwm_pkg::ctrl_primary_type   ctrl_ff;
	prescaled_dual_timer_pwm_pkg::ctrl_secondary_type ctrl_sec_ff;
	logic [7:0]        low_match_reg_ff, high_match_reg_ff, prescale_limit_ff;
	logic [7:0]        pre_cnt_ff, low_count_ff, high_count_ff, low_buf_ff, high_buf_ff;
	logic              low_wave_ff, high_wave_ff, irq_ff;
	logic [3:0]        pin_prev_ff;
	// Bus state
	logic              aw_have_ff, w_have_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [ADDR_W-1:0] awaddr_ff;
	logic [7:0]        wbyte_ff;
	logic              wlane_ff;
	logic [1:0]        bresp_ff, rresp_ff;
	logic [31:0]       rdata_ff;

	// Register index of a byte address
	function automatic logic [15:0] reg_index(input logic [ADDR_W-1:0] addr);
		reg_index = addr[prescaled_dual_timer_pwm_pkg::IDX_LSB +: 16];
	endfunction : reg_index
	// Index belongs to the register map
	function automatic logic is_mapped(input logic [15:0] idx);
		is_mapped = (idx >= prescaled_dual_timer_pwm_pkg::IDX_LOW_MATCH) &&
		            (idx <= prescaled_dual_timer_pwm_pkg::IDX_PRESCALE);
	endfunction : is_mapped

	// Mode decode
	wire logic [1:0] op_mode_field = ctrl_sec_ff.op_mode_field;
	wire logic       op_mode_bit0  = op_mode_field[0];
	wire logic [1:0] clock_source_sel = ctrl_ff.clock_source_sel;
	wire logic       mode_16bit    = (op_mode_field == prescaled_dual_timer_pwm_pkg::MODE_16BIT);
	wire logic       mode_dual     = (op_mode_field == prescaled_dual_timer_pwm_pkg::MODE_DUAL_TMR);
	wire logic       mode_pwm_tmr  = (op_mode_field == prescaled_dual_timer_pwm_pkg::MODE_PWM_TMR);
	wire logic       low_pwm       = op_mode_field[1];

	// Rising edges of the synchronous count sources
	wire logic [3:0] pin_now  = {oscillator_b, oscillator_a, event_pin_b, event_pin_a};
	wire logic [3:0] pin_rise = pin_now & ~pin_prev_ff;
	wire logic       event_rise = ctrl_sec_ff.event_pin_sel ? pin_rise[1] : pin_rise[0];

	// Prescaler run and count clock
	wire logic low_run = ctrl_ff.low_byte_go;
	wire logic high_run = op_mode_bit0 ? ctrl_ff.high_byte_go : ctrl_ff.low_byte_go;
	wire logic pre_run = ctrl_ff.low_byte_go | (op_mode_bit0 & ctrl_ff.high_byte_go);
	wire logic event_is_sys = mode_dual & ~ctrl_sec_ff.event_pin_sel;
	wire logic pre_tick =
		(clock_source_sel == prescaled_dual_timer_pwm_pkg::CKS_SYSTEM) ? 1'b1 :
		(clock_source_sel == prescaled_dual_timer_pwm_pkg::CKS_EVENT)  ? (event_is_sys | event_rise) :
		(clock_source_sel == prescaled_dual_timer_pwm_pkg::CKS_OSC_A)  ? pin_rise[2] : pin_rise[3];
	wire logic pre_match = pre_run & pre_tick & (pre_cnt_ff == prescale_limit_ff);

	// Low byte clock, match and overflow
	wire logic low_direct = mode_dual & (clock_source_sel == prescaled_dual_timer_pwm_pkg::CKS_EVENT);
	wire logic low_tick = low_run & (low_direct ? pin_rise[0] : pre_match);
	wire logic full_match = mode_16bit & low_tick &
		({high_count_ff, low_count_ff} == {high_buf_ff, low_buf_ff});
	wire logic low_byte_match = ~mode_16bit & low_tick & (low_count_ff == low_buf_ff);
	wire logic low_match = mode_16bit ? full_match : low_byte_match;
	wire logic low_ovf = low_tick & (low_count_ff == prescaled_dual_timer_pwm_pkg::BYTE_FULL) & ~full_match;
	// PWM keeps counting through the match so the period is 256 counts
	wire logic low_clear = ~low_run | (low_match & ~low_pwm);

	// High byte clock, match and overflow
	wire logic high_pwm = mode_pwm_tmr;
	wire logic high_tick = high_run & (op_mode_bit0 ? pre_match : low_ovf);
	wire logic high_match = ~mode_16bit & high_tick & (high_count_ff == high_buf_ff);
	wire logic high_ovf = high_tick & (high_count_ff == prescaled_dual_timer_pwm_pkg::BYTE_FULL);
	wire logic high_clear = ~high_run | full_match | (high_match & ~high_pwm);

	// Next counter values
	wire logic [7:0] nxt_pre_cnt = (~pre_run | pre_match) ? prescaled_dual_timer_pwm_pkg::BYTE_ZERO :
		pre_tick ? 8'(pre_cnt_ff + 8'h01) : pre_cnt_ff;
	wire logic [7:0] nxt_low_count = low_clear ? prescaled_dual_timer_pwm_pkg::BYTE_ZERO :
		low_tick ? 8'(low_count_ff + 8'h01) : low_count_ff;
	wire logic [7:0] nxt_high_count = high_clear ? prescaled_dual_timer_pwm_pkg::BYTE_ZERO :
		high_tick ? 8'(high_count_ff + 8'h01) : high_count_ff;
	// Match buffers follow when stopped, reload at count zero
	wire logic low_buf_load = ~low_run | (low_count_ff == prescaled_dual_timer_pwm_pkg::BYTE_ZERO);
	wire logic high_buf_load = ~high_run | (high_count_ff == prescaled_dual_timer_pwm_pkg::BYTE_ZERO);
	// Flag set events: count returns to zero while running, for the high flag only with high_byte_go set
	wire logic low_flag_set = low_pwm ? low_ovf : low_match;
	wire logic high_flag_set = ctrl_ff.high_byte_go & (high_pwm ? high_ovf : (high_match | full_match));

	// Output waveforms
	wire logic nxt_low_wave =
		(~low_run | mode_16bit) ? 1'b1 :
		mode_dual ? (low_wave_ff ^ low_match) :
		low_ovf ? 1'b1 : low_match ? 1'b0 : low_wave_ff;
	wire logic nxt_high_wave =
		~high_run ? 1'b1 :
		mode_16bit ? (high_wave_ff ^ full_match) :
		~high_pwm ? (high_wave_ff ^ high_match) :
		high_ovf ? 1'b1 : high_match ? 1'b0 : high_wave_ff;

	// Write decode: takes place when address and data are both held
	wire logic        do_write = aw_have_ff & w_have_ff & ~bvalid_ff;
	wire logic [15:0] w_idx = reg_index(awaddr_ff);
	wire logic        w_ok = is_mapped(w_idx);
	wire logic        w_lane = do_write & wlane_ff;
	wire logic        wr_ctrl = w_lane & (w_idx == prescaled_dual_timer_pwm_pkg::IDX_CTRL_PRI);
	wire prescaled_dual_timer_pwm_pkg::ctrl_primary_type wr_ctrl_val = wbyte_ff;
	// Flags: software clears by writing zero, a hardware set wins
	wire logic nxt_low_flag = low_flag_set |
		(ctrl_ff.low_match_flag & ~(wr_ctrl & ~wr_ctrl_val.low_match_flag));
	wire logic nxt_high_flag = high_flag_set |
		(ctrl_ff.high_match_flag & ~(wr_ctrl & ~wr_ctrl_val.high_match_flag));
	wire logic nxt_irq = (nxt_low_flag & ctrl_ff.low_irq_enable) | (nxt_high_flag & ctrl_ff.high_irq_enable);

	// Bus handshake next state
	wire logic aw_take = s_axi_awvalid & awready_ff;
	wire logic w_take = s_axi_wvalid & wready_ff;
	wire logic nxt_aw_have = (aw_have_ff & ~do_write) | aw_take;
	wire logic nxt_w_have = (w_have_ff & ~do_write) | w_take;
	wire logic nxt_bvalid = do_write | (bvalid_ff & ~s_axi_bready);
	wire logic ar_take = s_axi_arvalid & arready_ff;
	wire logic nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);
	wire logic [15:0] r_idx = reg_index(s_axi_araddr);
	wire logic [7:0] r_byte =
		(r_idx == prescaled_dual_timer_pwm_pkg::IDX_LOW_MATCH)  ? low_match_reg_ff :
		(r_idx == prescaled_dual_timer_pwm_pkg::IDX_HIGH_MATCH) ? high_match_reg_ff :
		(r_idx == prescaled_dual_timer_pwm_pkg::IDX_LOW_COUNT)  ? low_count_ff :
		(r_idx == prescaled_dual_timer_pwm_pkg::IDX_HIGH_COUNT) ? high_count_ff :
		(r_idx == prescaled_dual_timer_pwm_pkg::IDX_CTRL_PRI)   ? ctrl_ff :
		(r_idx == prescaled_dual_timer_pwm_pkg::IDX_CTRL_SEC)   ? {5'h00, ctrl_sec_ff} :
		(r_idx == prescaled_dual_timer_pwm_pkg::IDX_PRESCALE)   ? prescale_limit_ff :
		prescaled_dual_timer_pwm_pkg::BYTE_ZERO;

	// Bus channel flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= prescaled_dual_timer_pwm_pkg::RESP_OKAY;
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rresp_ff   <= prescaled_dual_timer_pwm_pkg::RESP_OKAY;
			rdata_ff   <= prescaled_dual_timer_pwm_pkg::WORD_ZERO;
			awaddr_ff  <= '0;
			wbyte_ff   <= prescaled_dual_timer_pwm_pkg::BYTE_ZERO;
			wlane_ff   <= 1'b0;
		end else begin
			aw_have_ff <= nxt_aw_have;
			w_have_ff  <= nxt_w_have;
			awready_ff <= ~nxt_aw_have & ~nxt_bvalid;
			wready_ff  <= ~nxt_w_have & ~nxt_bvalid;
			bvalid_ff  <= nxt_bvalid;
			arready_ff <= ~nxt_rvalid;
			rvalid_ff  <= nxt_rvalid;
			if (aw_take) begin
				awaddr_ff <= s_axi_awaddr;
			end
			if (w_take) begin
				wbyte_ff <= s_axi_wdata[7:0];
				wlane_ff <= s_axi_wstrb[0];
			end
			if (do_write) begin
				bresp_ff <= w_ok ? prescaled_dual_timer_pwm_pkg::RESP_OKAY : prescaled_dual_timer_pwm_pkg::RESP_SLVERR;
			end
			if (ar_take) begin
				rdata_ff <= {24'h000000, r_byte};
				rresp_ff <= is_mapped(r_idx) ? prescaled_dual_timer_pwm_pkg::RESP_OKAY :
				            prescaled_dual_timer_pwm_pkg::RESP_SLVERR;
			end
		end
	end

	// Software-written registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff           <= prescaled_dual_timer_pwm_pkg::CTRL_PRI_RESET;
			ctrl_sec_ff       <= prescaled_dual_timer_pwm_pkg::CTRL_SEC_RESET;
			low_match_reg_ff  <= prescaled_dual_timer_pwm_pkg::BYTE_ZERO;
			high_match_reg_ff <= prescaled_dual_timer_pwm_pkg::BYTE_ZERO;
			prescale_limit_ff <= prescaled_dual_timer_pwm_pkg::BYTE_ZERO;
		end else begin
			if (wr_ctrl) begin
				ctrl_ff <= wr_ctrl_val;
			end
			ctrl_ff.low_match_flag  <= nxt_low_flag;
			ctrl_ff.high_match_flag <= nxt_high_flag;
			if (w_lane && w_idx == prescaled_dual_timer_pwm_pkg::IDX_CTRL_SEC) begin
				ctrl_sec_ff <= wbyte_ff[2:0];
			end
			if (w_lane && w_idx == prescaled_dual_timer_pwm_pkg::IDX_LOW_MATCH) begin
				low_match_reg_ff <= wbyte_ff;
			end
			if (w_lane && w_idx == prescaled_dual_timer_pwm_pkg::IDX_HIGH_MATCH) begin
				high_match_reg_ff <= wbyte_ff;
			end
			if (w_lane && w_idx == prescaled_dual_timer_pwm_pkg::IDX_PRESCALE) begin
				prescale_limit_ff <= wbyte_ff;
			end
		end
	end

	// Counters, buffers and outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_cnt_ff    <= prescaled_dual_timer_pwm_pkg::BYTE_ZERO;
			low_count_ff  <= prescaled_dual_timer_pwm_pkg::BYTE_ZERO;
			high_count_ff <= prescaled_dual_timer_pwm_pkg::BYTE_ZERO;
			low_buf_ff    <= prescaled_dual_timer_pwm_pkg::BYTE_ZERO;
			high_buf_ff   <= prescaled_dual_timer_pwm_pkg::BYTE_ZERO;
			low_wave_ff   <= 1'b1;
			high_wave_ff  <= 1'b1;
			irq_ff        <= 1'b0;
			pin_prev_ff   <= 4'h0;
		end else begin
			pre_cnt_ff    <= nxt_pre_cnt;
			low_count_ff  <= nxt_low_count;
			high_count_ff <= nxt_high_count;
			if (low_buf_load) begin
				low_buf_ff <= low_match_reg_ff;
			end
			if (high_buf_load) begin
				high_buf_ff <= high_match_reg_ff;
			end
			low_wave_ff   <= nxt_low_wave;
			high_wave_ff  <= nxt_high_wave;
			irq_ff        <= nxt_irq;
			pin_prev_ff   <= pin_now;
		end
	end

	// Port drive
	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign low_wave_out  = low_wave_ff;
	assign high_wave_out = high_wave_ff;
	assign irq_request   = irq_ff;

	// Checks on counter, output, flag and write response behaviour
	property p_pre_stop;
		@(posedge aclk) disable iff (!aresetn)
		(!ctrl_ff.low_byte_go && !(op_mode_bit0 && ctrl_ff.high_byte_go)) |=> (pre_cnt_ff == 8'h00);
	endproperty
	a_pre_stop: assert property (p_pre_stop) else $error("prescaler not cleared while stopped");
	property p_pre_match;
		@(posedge aclk) disable iff (!aresetn)
		pre_match |-> (pre_cnt_ff == prescale_limit_ff) ##1 (pre_cnt_ff == 8'h00);
	endproperty
	a_pre_match: assert property (p_pre_match) else $error("prescaler match wrong");
	property p_low_stop_out;
		@(posedge aclk) disable iff (!aresetn)
		(!ctrl_ff.low_byte_go || mode_16bit) |=> low_wave_out;
	endproperty
	a_low_stop_out: assert property (p_low_stop_out) else $error("low output not high");
	property p_low_toggle;
		@(posedge aclk) disable iff (!aresetn)
		(mode_dual && low_run && low_match) |=> (low_wave_out != $past(low_wave_out));
	endproperty
	a_low_toggle: assert property (p_low_toggle) else $error("low output did not toggle");
	property p_low_pwm_set;
		@(posedge aclk) disable iff (!aresetn)
		(low_pwm && low_run && low_ovf) |=> low_wave_out;
	endproperty
	a_low_pwm_set: assert property (p_low_pwm_set) else $error("low PWM not set on overflow");
	property p_low_buf_follow;
		@(posedge aclk) disable iff (!aresetn)
		!ctrl_ff.low_byte_go |=> (low_buf_ff == $past(low_match_reg_ff));
	endproperty
	a_low_buf_follow: assert property (p_low_buf_follow) else $error("low buffer not following");
	property p_high_stop;
		@(posedge aclk) disable iff (!aresetn)
		(!op_mode_bit0 && !ctrl_ff.low_byte_go) |=> (high_count_ff == 8'h00) && high_wave_out;
	endproperty
	a_high_stop: assert property (p_high_stop) else $error("high counter not stopped");
	property p_full_clear;
		@(posedge aclk) disable iff (!aresetn)
		full_match |=> (low_count_ff == 8'h00) && (high_count_ff == 8'h00);
	endproperty
	a_full_clear: assert property (p_full_clear) else $error("16-bit pair not cleared");
	property p_high_pwm_clr;
		@(posedge aclk) disable iff (!aresetn)
		(high_pwm && high_run && high_match && !high_ovf) |=> !high_wave_out;
	endproperty
	a_high_pwm_clr: assert property (p_high_pwm_clr) else $error("high PWM not cleared on match");
	property p_low_flag_rise;
		@(posedge aclk) disable iff (!aresetn)
		$rose(ctrl_ff.low_match_flag) |-> $past(low_flag_set);
	endproperty
	a_low_flag_rise: assert property (p_low_flag_rise) else $error("low flag set without event");
	property p_bresp_hold;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");

	// Main scenarios
	c_low_toggle: cover property (@(posedge aclk) disable iff (!aresetn) mode_dual && low_match);
	c_full_match: cover property (@(posedge aclk) disable iff (!aresetn) full_match);
	c_low_pwm: cover property (@(posedge aclk) disable iff (!aresetn) low_pwm && low_ovf ##[1:600] low_match);
	c_high_flag: cover property (@(posedge aclk) disable iff (!aresetn) $rose(ctrl_ff.high_match_flag));

endmodule : prescaled_dual_timer_pwm

// ===== prescaled_dual_timer_pwm_pkg.sv
// Constants, register map and field layouts for the prescaled dual timer with PWM
package prescaled_dual_timer_pwm_pkg;

	// Bus geometry
	localparam int          ADDR_W          = 18;
	localparam int          DATA_W          = 32;
	localparam int          IDX_LSB         = 2;

	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_LOW_MATCH   = 16'h7f28;
	localparam logic [15:0] IDX_HIGH_MATCH  = 16'h7f29;
	localparam logic [15:0] IDX_LOW_COUNT   = 16'h7f2a;
	localparam logic [15:0] IDX_HIGH_COUNT  = 16'h7f2b;
	localparam logic [15:0] IDX_CTRL_PRI    = 16'h7f2c;
	localparam logic [15:0] IDX_CTRL_SEC    = 16'h7f2d;
	localparam logic [15:0] IDX_PRESCALE    = 16'h7f2e;

	// Operating modes of the two-bit mode field
	localparam logic [1:0]  MODE_16BIT      = 2'h0;
	localparam logic [1:0]  MODE_DUAL_TMR   = 2'h1;
	localparam logic [1:0]  MODE_PWM_TMR    = 2'h2;
	localparam logic [1:0]  MODE_DUAL_PWM   = 2'h3;

	// Count clock sources
	localparam logic [1:0]  CKS_SYSTEM      = 2'h0;
	localparam logic [1:0]  CKS_EVENT       = 2'h1;
	localparam logic [1:0]  CKS_OSC_A       = 2'h2;
	localparam logic [1:0]  CKS_OSC_B       = 2'h3;

	// Byte values and bus responses
	localparam logic [7:0]  BYTE_ZERO       = 8'h00;
	localparam logic [7:0]  BYTE_FULL       = 8'hff;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;

	// Primary control byte, bit 7 down to bit 0
	typedef struct packed {
		logic       high_byte_go;
		logic       high_match_flag;
		logic       high_irq_enable;
		logic [1:0] clock_source_sel;
		logic       low_byte_go;
		logic       low_match_flag;
		logic       low_irq_enable;
	} ctrl_primary_type;

	// Secondary control, bits 2 down to 0
	typedef struct packed {
		logic       event_pin_sel;
		logic [1:0] op_mode_field;
	} ctrl_secondary_type;

	localparam ctrl_primary_type   CTRL_PRI_RESET = 8'h00;
	localparam ctrl_secondary_type CTRL_SEC_RESET = 3'h0;

endpackage : prescaled_dual_timer_pwm_pkg

// ===== test_prescaled_dual_timer_pwm.sv
// Self-checking testbench for the prescaled dual timer with PWM outputs
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module test_prescaled_dual_timer_pwm;
	// Bench-driven signals
	logic        aclk    = 1'b0;
	logic        aresetn = 1'b0;
	logic [17:0] awaddr  = 18'h00000, araddr = 18'h00000;
	logic [31:0] wdata   = 32'h00000000;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [3:0]  src     = 4'h0;
	logic [3:0]  strb    = 4'h1;
	// Block outputs and captured answers
	logic        awready, wready, bvalid, arready, rvalid, low_wave_out, high_wave_out, irq_request;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] rdata;
	logic [7:0]  rd;
	logic [7:0]  ev_sec [4] = '{8'h01, 8'h04, 8'h01, 8'h01};
	logic [7:0]  ev_ctl [4] = '{8'h0c, 8'h0c, 8'h14, 8'h1c};
	int          miscompares = 0, tests_run = 0, n;

	// Clock at 125 MHz
	always #4 aclk = ~aclk;

	// Device under test; only strobe bit 0 gates a write
	prescaled_dual_timer_pwm dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .event_pin_a(src[0]),
		.event_pin_b(src[1]), .oscillator_a(src[2]), .oscillator_b(src[3]), .low_wave_out(low_wave_out),
		.high_wave_out(high_wave_out), .irq_request(irq_request));

	// Byte address of a register index
	function automatic logic [17:0] ad(input logic [15:0] idx);
		return {idx, 2'b00};
	endfunction : ad

	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [17:0] a, input logic [7:0] d);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done  = 1'b0;
		awaddr  <= a;
		wdata   <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
		@(posedge aclk); // Let an edge pass before the next request
	endtask : wr

	// Read: rready held until the data is seen
	task automatic rdr(input logic [17:0] a);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		resp = rresp;
		rd = rdata[7:0];
		rready <= 1'b0;
		@(posedge aclk); // Let an edge pass before the next request
	endtask : rdr

	// Stop, then load mode, prescale, both match bytes and the go bits
	task automatic setup(input logic [7:0] sec, pre, lr, hr, ctl);
		wr(ad(prescaled_dual_timer_pwm_pkg::IDX_CTRL_PRI), 8'h00);
		wr(ad(prescaled_dual_timer_pwm_pkg::IDX_CTRL_SEC), sec);
		wr(ad(prescaled_dual_timer_pwm_pkg::IDX_PRESCALE), pre);
		wr(ad(prescaled_dual_timer_pwm_pkg::IDX_LOW_MATCH), lr);
		wr(ad(prescaled_dual_timer_pwm_pkg::IDX_HIGH_MATCH), hr);
		wr(ad(prescaled_dual_timer_pwm_pkg::IDX_CTRL_PRI), ctl);
	endtask : setup

	// Cycles spent in the next whole phase at level lvl of one output
	task automatic span(input bit hi, input logic lvl);
		while ((hi ? high_wave_out : low_wave_out) !== ~lvl) @(posedge aclk);
		while ((hi ? high_wave_out : low_wave_out) !== lvl) @(posedge aclk);
		n = 0;
		while ((hi ? high_wave_out : low_wave_out) === lvl) begin
			@(posedge aclk);
			n++;
		end
	endtask : span

	// Verdict and end of run
	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish

	// Watchdog well beyond the few thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		$display("Watchdog expired");
		tally_and_finish();
	end

	// Test sequence
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		`CHK("low wave idle", 1'b1, low_wave_out)
		`CHK("high wave idle", 1'b1, high_wave_out)
		wr(ad(prescaled_dual_timer_pwm_pkg::IDX_LOW_COUNT), 8'h55);
		rdr(ad(prescaled_dual_timer_pwm_pkg::IDX_LOW_COUNT));
		`CHK("stopped count", 8'h00, rd)
		wr(18'h00010, 8'h01);
		`CHK("unmapped write", prescaled_dual_timer_pwm_pkg::RESP_SLVERR, resp)
		rdr(18'h00010);
		`CHK("unmapped read", prescaled_dual_timer_pwm_pkg::RESP_SLVERR, resp)
		strb <= 4'h0;
		wr(ad(prescaled_dual_timer_pwm_pkg::IDX_LOW_MATCH), 8'h77);
		strb <= 4'h1;
		rdr(ad(prescaled_dual_timer_pwm_pkg::IDX_LOW_MATCH));
		`CHK("masked write", 8'h00, rd)
		$display("Test registers done");
		// Mode 1, prescale 1: low match 3, high match 1
		setup(8'h01, 8'h01, 8'h03, 8'h01, 8'h84);
		span(1'b0, 1'b1);
		`CHK("mode 1 low phase", (3 + 1) * (1 + 1), n)
		span(1'b1, 1'b1);
		`CHK("mode 1 high phase", (1 + 1) * (1 + 1), n)
		rdr(ad(prescaled_dual_timer_pwm_pkg::IDX_CTRL_PRI));
		`CHK("both flags", 8'hc6, rd)
		wr(ad(prescaled_dual_timer_pwm_pkg::IDX_CTRL_PRI), 8'hc7);
		repeat (2) @(posedge aclk);
		`CHK("irq enabled", 1'b1, irq_request)
		wr(ad(prescaled_dual_timer_pwm_pkg::IDX_CTRL_PRI), 8'h84);
		repeat (2) @(posedge aclk);
		`CHK("irq masked", 1'b0, irq_request)
		wr(ad(prescaled_dual_timer_pwm_pkg::IDX_LOW_MATCH), 8'h05);
		span(1'b0, 1'b1);
		span(1'b0, 1'b0);
		`CHK("new low match", (5 + 1) * (1 + 1), n)
		wr(ad(prescaled_dual_timer_pwm_pkg::IDX_CTRL_PRI), 8'h80);
		span(1'b1, 1'b1);
		span(1'b1, 1'b0);
		`CHK("high alone", (1 + 1) * (1 + 1), n)
		`CHK("low stopped", 1'b1, low_wave_out)
		$display("Test mode 1 done");
		// Mode 0: sixteen-bit match 0x0103, prescale 0
		setup(8'h00, 8'h00, 8'h03, 8'h01, 8'h04);
		span(1'b1, 1'b0);
		`CHK("mode 0 phase", 256 + 3 + 1, n)
		`CHK("mode 0 low wave", 1'b1, low_wave_out)
		rdr(ad(prescaled_dual_timer_pwm_pkg::IDX_CTRL_PRI));
		`CHK("mode 0 flags", 8'h06, rd)
		$display("Test mode 0 done");
		// PWM modes 2 and 3: low match 0x40, high match 0x00 in mode 2 and 0x10 in mode 3
		for (int m = 2; m < 4; m++) begin
			setup(8'(m), 8'h00, 8'h40, (m == 2) ? 8'h00 : 8'h10, 8'h84);
			span(1'b0, 1'b1);
			`CHK("pwm high time", 8'h40 + 1, n)
			if (m == 3) begin
				span(1'b1, 1'b1);
				`CHK("mode 3 high toggle", 8'h10 + 1, n)
			end else begin
				`CHK("mode 2 high pwm", 1'b0, high_wave_out)
			end
		end
		$display("Test pwm done");
		// Event pins and oscillators: five rising edges each
		for (int i = 0; i < 4; i++) begin
			setup(ev_sec[i], 8'h00, 8'h20, 8'h20, ev_ctl[i]);
			repeat (5) begin
				src[i] <= 1'b1;
				repeat (2) @(posedge aclk);
				src[i] <= 1'b0;
				repeat (2) @(posedge aclk);
			end
			repeat (4) @(posedge aclk);
			rdr(ad(prescaled_dual_timer_pwm_pkg::IDX_LOW_COUNT));
			`CHK("edges counted", 8'h05, rd)
		end
		wr(ad(prescaled_dual_timer_pwm_pkg::IDX_CTRL_PRI), 8'h00);
		rdr(ad(prescaled_dual_timer_pwm_pkg::IDX_LOW_COUNT));
		`CHK("count after stop", 8'h00, rd)
		$display("Test count sources done");
		tally_and_finish();
	end
endmodule : test_prescaled_dual_timer_pwm
